// File: common/tsp_defines.svh
// Register offsets, field positions, reset values and timing constants
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

// ************************************************************
// Register map
// ************************************************************
`define TSP_ADDR_W        8
`define TSP_OFF_CTRL      8'h00
`define TSP_OFF_STAT      8'h04
`define TSP_OFF_BLK0      8'h40
`define TSP_OFF_SIG0      8'h80
`define TSP_REG_STRIDE    8'h04
`define TSP_CTRL_W        16
`define TSP_CTRL_RST      16'h0000
`define TSP_CTRL_ES       0
`define TSP_CTRL_LEGACY   1
`define TSP_CTRL_DIROUT   2
`define TSP_CTRL_E1       3
`define TSP_CTRL_CHCLK    8
`define TSP_BLK_RST       32'h0000_0000

// ************************************************************
// Frame timing
// ************************************************************
`define TSP_FRAME_HZ      8000
`define TSP_BP_HZ         16384000
`define TSP_SIG_MAX_HZ    16384000
`define TSP_PCLK_HZ       50000000
`define TSP_LSB_IDX       3'h7
`define TSP_T1_LAST_CH    5'h17
`define TSP_E1_LAST_CH    5'h1F

`endif

// File: common/tsp_pkg.sv
// Types shared by the transmit sync and signaling port
`include "tsp_defines.svh"
package tsp_pkg;
	typedef enum logic [1:0] {
		TSP_SYNC_OFF,
		TSP_SYNC_IN,
		TSP_SYNC_OUT
	} tsp_sync_e;
	typedef logic [`TSP_ADDR_W-1:0] tsp_addr_t;
endpackage : tsp_pkg

// File: rtl/tsp_port.sv
// One transmit port: channel timing, signaling capture, dual-function pin
`timescale 1ns/1ps
`default_nettype none
`include "tsp_defines.svh"
module tsp_port
	import tsp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        bit_rise,
	input  wire logic        bit_fall,
	input  wire logic        frame_sync,
	input  wire logic        sig_in,
	input  wire logic        e1_mode,
	input  wire logic        chclk_sel,
	input  wire logic [31:0] blk_map,
	output logic             dual_out,
	output logic [7:0]       sig_byte,
	output logic [4:0]       ch_num
);
	typedef struct packed {
		logic       pend;
		logic       fbit;
		logic [2:0] bit_idx;
		logic [4:0] ch;
		logic [7:0] shreg;
		logic [7:0] sig_byte;
		logic [4:0] sig_ch;
		logic       dual;
	} tsp_port_s;
	tsp_port_s q, d;
	logic      last_ch;

	// ************************************************************
	// Bit and channel counting
	// ************************************************************
	always_comb begin
		d = q;
		last_ch = (q.ch == (e1_mode ? `TSP_E1_LAST_CH : `TSP_T1_LAST_CH));
		if (frame_sync) begin
			d.pend = 1'b1;
		end
		if (bit_rise) begin
			if (q.pend | frame_sync) begin
				d.pend = 1'b0;
				d.fbit = ~e1_mode;
				d.bit_idx = '0;
				d.ch = '0;
			end else if (q.fbit) begin
				d.fbit = 1'b0;
			end else if (q.bit_idx == `TSP_LSB_IDX) begin
				d.bit_idx = '0;
				d.ch = last_ch ? '0 : q.ch + 5'h01;
				d.fbit = last_ch & ~e1_mode;
			end else begin
				d.bit_idx = q.bit_idx + 3'h1;
			end
		end
		// Falling edge so the driver can change on the rising one
		if (bit_fall & ~q.fbit) begin
			d.shreg = {q.shreg[6:0], sig_in};
			if (q.bit_idx == `TSP_LSB_IDX) begin
				d.sig_byte = {q.shreg[6:0], sig_in};
				d.sig_ch = q.ch;
			end
		end
		if (chclk_sel) begin
			d.dual = ~d.fbit & (d.bit_idx == `TSP_LSB_IDX);
		end else begin
			d.dual = ~d.fbit & blk_map[d.ch];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dual_out = q.dual;
	assign sig_byte = q.sig_byte;
	assign ch_num = q.sig_ch;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_lsb_step;
		bit_rise && !q.pend && !frame_sync && !q.fbit && q.bit_idx == 3'h6;
	endsequence
	a_chclk_on_lsb: assert property (@(posedge clk) disable iff (!rstn)
		s_lsb_step ##0 chclk_sel |=> dual_out)
		else $error("channel clock missing on LSB");
	a_chblk_follows_map: assert property (@(posedge clk) disable iff (!rstn)
		!chclk_sel && !d.fbit && !q.pend |=> dual_out == $past(blk_map[d.ch]))
		else $error("channel block differs from map");
	a_sig_capture: assert property (@(posedge clk) disable iff (!rstn)
		bit_fall && !q.fbit && q.bit_idx == `TSP_LSB_IDX |=> sig_byte[0] == $past(sig_in))
		else $error("signaling bit not captured");
endmodule : tsp_port
`default_nettype wire

// File: rtl/tsp_top.sv
// Transmit system sync, signaling and channel block/clock port with APB
`timescale 1ns/1ps
`default_nettype none
`include "tsp_defines.svh"
module tsp_top
	import tsp_pkg::*;
#(
	parameter int NPORTS     = 8,
	parameter int BP_HZ      = `TSP_BP_HZ,
	parameter int SIG_MAX_HZ = `TSP_SIG_MAX_HZ
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire tsp_addr_t         paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [NPORTS-1:0] tx_line_clock,
	input  wire logic [NPORTS-1:0] tx_frame_sync,
	input  wire logic [NPORTS-1:0] tx_signaling_in,
	input  wire logic              tx_system_clock,
	input  wire logic              backplane_clock,
	input  wire logic              tx_sys_sync_io_i,
	output logic                   tx_sys_sync_io_o,
	output logic                   tx_sys_sync_io_oe,
	output logic [NPORTS-1:0]      tx_channel_block
);
	// ************************************************************
	// Constants and checks
	// ************************************************************
	localparam int BP_CLKS = BP_HZ / `TSP_FRAME_HZ;
	localparam int BP_W = $clog2(BP_CLKS);
	localparam logic [BP_W-1:0] BP_LAST = BP_W'(BP_CLKS - 1);

	initial begin
		if (NPORTS < 1 || NPORTS > 8) begin
			$error("NPORTS must be 1 to 8");
		end
		if (BP_CLKS < 2) begin
			$error("backplane clock too slow for frame pulse");
		end
		// Each half period of the fastest stream must span a pclk cycle
		if (`TSP_PCLK_HZ <= 2 * SIG_MAX_HZ) begin
			$error("pclk too slow for signaling stream rate");
		end
	end

	typedef struct packed {
		logic [NPORTS-1:0]             lclk_s1;
		logic [NPORTS-1:0]             lclk_s2;
		logic [NPORTS-1:0]             lclk_s3;
		logic [NPORTS-1:0]             fs_s1;
		logic [NPORTS-1:0]             fs_s2;
		logic [NPORTS-1:0]             fs_smp;
		logic [NPORTS-1:0]             sig_s1;
		logic [NPORTS-1:0]             sig_s2;
		logic                          sclk_s1;
		logic                          sclk_s2;
		logic                          sclk_s3;
		logic                          bclk_s1;
		logic                          bclk_s2;
		logic                          bclk_s3;
		logic                          ss_s1;
		logic                          ss_s2;
		logic                          ss_smp;
		logic [BP_W-1:0]               bp_cnt;
		logic                          sync_o;
		logic                          oe;
		logic [`TSP_CTRL_W-1:0]        ctrl;
		logic [NPORTS-1:0][31:0]       blk;
		logic [NPORTS-1:0]             seen;
		logic [31:0]                   prdata;
		logic                          pready;
		logic                          pslverr;
	} tsp_top_s;

	tsp_top_s          q, d;
	tsp_sync_e         sync_mode;
	logic              es, legacy, e1;
	logic              sclk_rise, sclk_fall, bclk_rise;
	logic              shared_in_pulse, gen_pulse, shared_pulse;
	logic [NPORTS-1:0] lclk_rise, lclk_fall;
	logic [NPORTS-1:0] bit_rise, bit_fall, own_pulse, port_sync;
	logic [NPORTS-1:0][7:0] sig_byte;
	logic [NPORTS-1:0][4:0] sig_ch;
	logic              access, wr_done, hit;
	logic [31:0]       rd;

	// ************************************************************
	// Mode decode and clock edges
	// ************************************************************
	assign es = q.ctrl[`TSP_CTRL_ES];
	assign legacy = q.ctrl[`TSP_CTRL_LEGACY];
	assign e1 = q.ctrl[`TSP_CTRL_E1];

	always_comb begin
		if (!legacy) begin
			sync_mode = TSP_SYNC_OFF;
		end else if (q.ctrl[`TSP_CTRL_DIROUT]) begin
			sync_mode = TSP_SYNC_OUT;
		end else begin
			sync_mode = TSP_SYNC_IN;
		end
	end

	// Edges come from stages two and three only
	assign sclk_rise = q.sclk_s2 & ~q.sclk_s3;
	assign sclk_fall = ~q.sclk_s2 & q.sclk_s3;
	assign bclk_rise = q.bclk_s2 & ~q.bclk_s3;
	assign lclk_rise = q.lclk_s2 & ~q.lclk_s3;
	assign lclk_fall = ~q.lclk_s2 & q.lclk_s3;

	// Shared pin caught at system clock rise
	assign shared_in_pulse = sclk_rise & q.ss_s2 & ~q.ss_smp;
	assign gen_pulse = bclk_rise & (q.bp_cnt == BP_LAST);
	assign shared_pulse = es & (((sync_mode == TSP_SYNC_IN) & shared_in_pulse)
		| ((sync_mode == TSP_SYNC_OUT) & gen_pulse));

	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			bit_rise[p] = es ? sclk_rise : lclk_rise[p];
			bit_fall[p] = es ? sclk_fall : lclk_fall[p];
			own_pulse[p] = bit_rise[p] & q.fs_s2[p] & ~q.fs_smp[p];
			port_sync[p] = legacy ? shared_pulse : own_pulse[p];
		end
	end

	// ************************************************************
	// Register bus decode
	// ************************************************************
	assign access = psel & penable & ~q.pready;
	assign wr_done = psel & penable & q.pready & pwrite & ~q.pslverr;

	always_comb begin
		hit = 1'b0;
		rd = '0;
		if (paddr == `TSP_OFF_CTRL) begin
			hit = 1'b1;
			rd[`TSP_CTRL_W-1:0] = q.ctrl;
		end
		if (paddr == `TSP_OFF_STAT) begin
			hit = 1'b1;
			rd[NPORTS-1:0] = q.seen;
		end
		for (int p = 0; p < NPORTS; p++) begin
			if (paddr == `TSP_OFF_BLK0 + 8'(p) * `TSP_REG_STRIDE) begin
				hit = 1'b1;
				rd = q.blk[p];
			end
			if (paddr == `TSP_OFF_SIG0 + 8'(p) * `TSP_REG_STRIDE) begin
				hit = 1'b1;
				rd[12:0] = {sig_ch[p], sig_byte[p]};
			end
		end
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		d = q;
		d.lclk_s1 = tx_line_clock;
		d.lclk_s2 = q.lclk_s1;
		d.lclk_s3 = q.lclk_s2;
		d.fs_s1 = tx_frame_sync;
		d.fs_s2 = q.fs_s1;
		d.sig_s1 = tx_signaling_in;
		d.sig_s2 = q.sig_s1;
		d.sclk_s1 = tx_system_clock;
		d.sclk_s2 = q.sclk_s1;
		d.sclk_s3 = q.sclk_s2;
		d.bclk_s1 = backplane_clock;
		d.bclk_s2 = q.bclk_s1;
		d.bclk_s3 = q.bclk_s2;
		d.ss_s1 = tx_sys_sync_io_i;
		d.ss_s2 = q.ss_s1;
		for (int p = 0; p < NPORTS; p++) begin
			if (bit_rise[p]) begin
				d.fs_smp[p] = q.fs_s2[p];
			end
		end
		if (sclk_rise) begin
			d.ss_smp = q.ss_s2;
		end
		// Frame pulse generator free-runs on the backplane clock
		if (bclk_rise) begin
			d.bp_cnt = gen_pulse ? '0 : q.bp_cnt + BP_W'(1);
			d.sync_o = es & (sync_mode == TSP_SYNC_OUT) & gen_pulse;
		end
		if (!es || sync_mode != TSP_SYNC_OUT) begin
			d.sync_o = 1'b0;
		end
		d.oe = (sync_mode == TSP_SYNC_OUT);
		// Hardware set wins over a clear in the same cycle
		d.seen = q.seen;
		if (wr_done && paddr == `TSP_OFF_STAT) begin
			d.seen = q.seen & ~pwdata[NPORTS-1:0];
		end
		d.seen = d.seen | port_sync;
		// One wait state; writes land on the completing edge
		d.pready = access;
		d.pslverr = access & ~hit;
		d.prdata = (access & hit & ~pwrite) ? rd : '0;
		if (wr_done) begin
			if (paddr == `TSP_OFF_CTRL) begin
				d.ctrl = pwdata[`TSP_CTRL_W-1:0];
			end
			for (int p = 0; p < NPORTS; p++) begin
				if (paddr == `TSP_OFF_BLK0 + 8'(p) * `TSP_REG_STRIDE) begin
					d.blk[p] = pwdata;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ctrl <= `TSP_CTRL_RST;
			q.blk <= {NPORTS{`TSP_BLK_RST}};
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign tx_sys_sync_io_o = q.sync_o;
	assign tx_sys_sync_io_oe = q.oe;

	// ************************************************************
	// Ports
	// ************************************************************
	for (genvar g = 0; g < NPORTS; g++) begin : g_port
		tsp_port u_port (
			.clk        (pclk),
			.rstn       (presetn),
			.bit_rise   (bit_rise[g]),
			.bit_fall   (bit_fall[g]),
			.frame_sync (port_sync[g]),
			.sig_in     (q.sig_s2[g]),
			.e1_mode    (e1),
			.chclk_sel  (q.ctrl[`TSP_CTRL_CHCLK + g]),
			.blk_map    (q.blk[g]),
			.dual_out   (tx_channel_block[g]),
			.sig_byte   (sig_byte[g]),
			.ch_num     (sig_ch[g])
		);
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_gen_wrap;
		bclk_rise && q.bp_cnt == BP_LAST && es && sync_mode == TSP_SYNC_OUT;
	endsequence
	sequence s_pulse_out;
		tx_sys_sync_io_o && tx_sys_sync_io_oe;
	endsequence

	a_gen_frame_pulse: assert property (s_gen_wrap |=> s_pulse_out)
		else $error("frame pulse not generated at wrap");
	a_pulse_only_wrap: assert property ($rose(tx_sys_sync_io_o) |-> q.bp_cnt == '0)
		else $error("frame pulse away from counter wrap");
	a_oe_out_only: assert property (tx_sys_sync_io_oe |->
		$past(legacy) && $past(q.ctrl[`TSP_CTRL_DIROUT]))
		else $error("shared pin driven outside output mode");
	a_default_unused: assert property (!legacy |-> ##1 !tx_sys_sync_io_oe)
		else $error("shared pin active without legacy mode");
	a_all_ports_align: assert property (legacy && shared_pulse |-> &port_sync)
		else $error("shared sync did not reach every port");
	a_own_sync_ignored: assert property (legacy && !shared_pulse |-> port_sync == '0)
		else $error("per-port sync used in legacy mode");
	a_sync_on_sysclk: assert property (shared_in_pulse |-> sclk_rise && $past(q.ss_s1))
		else $error("shared sync not taken on system clock");
	a_store_off_edge: assert property (!es |-> bit_fall[0] == lclk_fall[0])
		else $error("line clock fall not used");
	a_store_on_edge: assert property (es |-> bit_fall == {NPORTS{sclk_fall}})
		else $error("system clock fall not used");
	a_in_boundary: assert property (es && sync_mode == TSP_SYNC_IN && shared_in_pulse
		|=> q.seen[0])
		else $error("input sync did not mark boundary");
	a_bus_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("bus answer late");
endmodule : tsp_top
`default_nettype wire

// File: tb/tsp_far_model.sv
// Far-side model: bit clocks, sync pulses and serial signaling streams
`timescale 1ns/1ps
`default_nettype none
module tsp_far_model #(
	parameter int NPORTS = 8
) (
	input  wire logic         pclk,
	input  wire logic         es,
	input  wire logic         e1,
	input  wire logic         skew,
	input  wire logic         sync_go,
	output logic [NPORTS-1:0] tx_line_clock,
	output logic              tx_system_clock,
	output logic              backplane_clock,
	output logic [NPORTS-1:0] tx_frame_sync,
	output logic [NPORTS-1:0] tx_signaling_in,
	output logic              shared_drv
);
	// ************************************************************
	// Bit clock of 8 pclk; every change lands just after a pclk rise
	// ************************************************************
	logic [2:0]        ph_q    = 3'h0;
	logic [2:0]        pos_q   = 3'h0;
	logic [3:0]        hist_q  = 4'h0;
	logic              req_q   = 1'b0;
	logic              first_q = 1'b0;
	logic [NPORTS-1:0] sig_q   = '0;
	logic [7:0]        pat;
	logic              start;
	always @(posedge pclk) begin
		ph_q <= ph_q + 3'h1;
		if (sync_go)
			req_q <= 1'b1;
		if (ph_q == 3'h4) begin
			hist_q <= {hist_q[2:0], req_q}; // One bit wide, moved after the fall
			req_q  <= sync_go;
		end
		if (ph_q == 3'h0) begin
			// No framing bit in E1, so channel 0 starts one bit sooner
			start   = e1 ? hist_q[0] : first_q;
			first_q <= hist_q[0];
			pos_q   <= start ? 3'h1 : pos_q + 3'h1;
			for (int p = 0; p < NPORTS; p++) begin
				pat      = 8'h96 ^ 8'(p);
				sig_q[p] <= pat[start ? 3'h7 : 3'h7 - pos_q]; // MSB first, after rise
			end
		end
	end
	// Unused bit clock held low, as a board without it would tie it
	assign tx_system_clock = es & ~ph_q[2];
	assign tx_line_clock   = {NPORTS{~es & ~ph_q[2]}};
	assign backplane_clock = ph_q[1];
	// Skewed port syncs expose a design that listens to the wrong pins
	assign tx_frame_sync   = {NPORTS{skew ? hist_q[3] : hist_q[0]}};
	assign tx_signaling_in = sig_q;
	assign shared_drv      = hist_q[0];
endmodule : tsp_far_model
`default_nettype wire

// File: tb/tsp_top_tb.sv
// Self-checking bench for the transmit sync and signaling port
`timescale 1ns/1ps
`default_nettype none
`include "tsp_defines.svh"
module tsp_top_tb;
	import tsp_pkg::*;
	localparam int NP = 8;
	typedef struct packed {
		logic es; logic e1; logic chclk; logic [31:0] blk; logic [8:0] nbits; logic [8:0] hi;
	} tsp_row_s;
	logic          pclk    = 1'b0;
	logic          presetn = 1'b0;
	logic          psel    = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite  = 1'b0;
	tsp_addr_t     paddr   = '0;
	logic [31:0]   pwdata  = '0;
	logic          es      = 1'b0;
	logic          e1m     = 1'b0;
	logic          skew    = 1'b0;
	logic          sync_go = 1'b0;
	logic [31:0]   prdata, r, c0, c1;
	logic          pready, pslverr, io_o, io_oe, drv, sys_clk, bp_clk, e;
	logic [NP-1:0] lclk, fsync, sig, blk;
	int            fails      = 0;
	int            n_compared = 0;
	wire logic     io_i    = io_oe ? io_o : drv;
	wire logic     bit_clk = sys_clk | lclk[0];
	tsp_row_s      rows [5] = '{
		'{1'b0, 1'b1, 1'b1, 32'h0000_0000, 9'h100, 9'h020},
		'{1'b1, 1'b1, 1'b0, 32'h8000_0005, 9'h100, 9'h018},
		'{1'b0, 1'b0, 1'b1, 32'h0000_0000, 9'h0C1, 9'h018},
		'{1'b1, 1'b0, 1'b0, 32'h00FF_FFFF, 9'h0C1, 9'h0C0},
		'{1'b0, 1'b0, 1'b0, 32'hFF00_0000, 9'h0C1, 9'h000}};
	tsp_top #(.NPORTS(NP), .BP_HZ(80000)) tsp_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_line_clock(lclk), .tx_frame_sync(fsync), .tx_signaling_in(sig),
		.tx_system_clock(sys_clk), .backplane_clock(bp_clk), .tx_sys_sync_io_i(io_i),
		.tx_sys_sync_io_o(io_o), .tx_sys_sync_io_oe(io_oe), .tx_channel_block(blk));
	tsp_far_model #(.NPORTS(NP)) tsp_far_model_inst (
		.pclk(pclk), .es(es), .e1(e1m), .skew(skew), .sync_go(sync_go), .tx_line_clock(lclk),
		.tx_system_clock(sys_clk), .backplane_clock(bp_clk), .tx_frame_sync(fsync),
		.tx_signaling_in(sig), .shared_drv(drv));
	always #10 pclk = ~pclk;
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		if (n >= 50)
			fails++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic sync_check(input logic [31:0] ctrl, input logic s);
		es   <= ctrl[0];
		e1m  <= ctrl[3];
		skew <= s;
		apb(1'b1, `TSP_OFF_CTRL, ctrl, r, e);
		repeat (20) @(posedge bit_clk);
		@(posedge pclk) sync_go <= 1'b1;
		@(posedge pclk) sync_go <= 1'b0;
		repeat (40) @(posedge bit_clk);
		for (int p = 0; p < NP; p++) begin
			apb(1'b0, `TSP_OFF_SIG0 + 8'(p) * `TSP_REG_STRIDE, 32'h0, r, e);
			chk("sig byte", {24'h0, 8'h96 ^ 8'(p)}, {24'h0, r[7:0]});
		end
		apb(1'b0, `TSP_OFF_STAT, 32'h0, r, e);
		chk("sync seen", 32'h0000_00FF, r);
		apb(1'b1, `TSP_OFF_STAT, 32'h0000_00FF, r, e);
		apb(1'b0, `TSP_OFF_STAT, 32'h0, r, e);
		chk("seen cleared", 32'h0, r);
		$display("sync test done ctrl %h", ctrl);
	endtask : sync_check
	task automatic out_check(input logic [31:0] ctrl, input logic [31:0] nr_x,
			input logic [31:0] nh_x, input logic oe_x);
		logic [31:0] nr;
		logic [31:0] nh;
		logic        last;
		apb(1'b1, `TSP_OFF_CTRL, ctrl, r, e);
		repeat (60) @(posedge pclk);
		nr   = 32'h0;
		nh   = 32'h0;
		last = io_o;
		repeat (400) begin
			@(posedge pclk);
			nh   = nh + 32'(io_o);
			nr   = nr + 32'(io_o & ~last);
			last = io_o;
		end
		chk("pulse rises", nr_x, nr);
		chk("pulse highs", nh_x, nh);
		chk("drive enable", {31'h0, oe_x}, {31'h0, io_oe});
		$display("output test done ctrl %h", ctrl);
	endtask : out_check
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			es <= rows[i].es;
			apb(1'b1, `TSP_OFF_CTRL, {16'h0, {8{rows[i].chclk}}, 4'h0, rows[i].e1, 2'h0, rows[i].es},
				r, e);
			apb(1'b1, `TSP_OFF_BLK0, rows[i].blk, r, e);
			repeat (300) @(posedge bit_clk);
			c0 = 32'h0;
			c1 = 32'h0;
			repeat (rows[i].nbits) begin
				@(posedge bit_clk);
				c0 = c0 + 32'(blk[0]);
				c1 = c1 + 32'(blk[1]);
			end
			chk("port0 highs", 32'(rows[i].hi), c0);
			chk("port1 highs", rows[i].chclk ? 32'(rows[i].hi) : 32'h0, c1);
			$display("row %0d done", i);
		end
		sync_check(32'h0000_000B, 1'b1);
		// Second reset in mid-run clears config and the stale captures
		@(posedge pclk) presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("blk in reset", 32'h0, {24'h0, blk});
		chk("oe in reset", 32'h0, {31'h0, io_oe});
		@(posedge pclk) presetn <= 1'b1;
		apb(1'b0, `TSP_OFF_CTRL, 32'h0, r, e);
		chk("ctrl reset", 32'h0, r);
		apb(1'b0, `TSP_OFF_BLK0, 32'h0, r, e);
		chk("blk0 reset", 32'h0, r);
		apb(1'b0, 8'h3C, 32'h0, r, e);
		chk("unmapped err", {31'h0, 1'b1}, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		$display("reset test done");
		sync_check(32'h0000_0008, 1'b0);
		sync_check(32'h0000_0003, 1'b1);
		es <= 1'b1;
		out_check(32'h0000_0007, 32'hA, 32'h28, 1'b1);
		out_check(32'h0000_0006, 32'h0, 32'h0, 1'b1);
		out_check(32'h0000_0005, 32'h0, 32'h0, 1'b0);
		out_check(32'h0000_0003, 32'h0, 32'h0, 1'b0);
		wrap_up();
	end
	initial begin
		repeat (80000) @(posedge pclk);
		fails++;
		wrap_up();
	end
endmodule : tsp_top_tb
`default_nettype wire
